// ### hdl/cmd_status_pkg.sv
// Package for the host controller command and status register block
`default_nettype none
package cmd_status_pkg;

    // ==========================================
    // Register map
    localparam logic [15:0] CMD_STATUS_OFFSET = 16'hd008;
    localparam logic [15:0] IRQ_STATUS_OFFSET = 16'hd100;
    localparam logic [15:0] IRQ_MASK_OFFSET = 16'hd104;

    // ==========================================
    // Field positions of command_status
    localparam int SOFT_RESET_POS = 0;
    localparam int CONTROL_PENDING_POS = 1;
    localparam int BULK_PENDING_POS = 2;
    localparam int OWNER_CHANGE_POS = 3;
    localparam int TALLY_LSB = 16;
    localparam int TALLY_MSB = 17;

    // Event bits of the local interrupt status and mask
    localparam int EV_OVERRUN_POS = 0;
    localparam int EV_OWNER_POS = 1;
    localparam int EV_RESET_DONE_POS = 2;
    localparam int EV_WIDTH = 3;

    // ==========================================
    // Reset values
    localparam logic [1:0] TALLY_RESET = 2'h0;
    localparam logic [EV_WIDTH-1:0] EV_RESET = 3'h0;
    localparam logic [31:0] RDATA_RESET = 32'h0;

    // ==========================================
    // Timing
    localparam int CLOCK_MHZ = 200;
    localparam int RESET_LIMIT_US = 10;
    localparam int RESET_HOLD_US = 1;
    // Soft reset runs a fixed hold well inside the limit; longest time rounds down
    localparam int RESET_LIMIT_CYCLES = RESET_LIMIT_US * CLOCK_MHZ;
    localparam int RESET_HOLD_CYCLES = RESET_HOLD_US * CLOCK_MHZ;
    localparam int RESET_CNT_W = 12;

    typedef enum logic [1:0] {
        SR_IDLE = 2'b00,
        SR_HOLD = 2'b01,
        SR_DONE = 2'b11
    } soft_reset_state_t;

    typedef struct packed {
        logic soft_reset_cmd;
        logic control_list_pending;
        logic bulk_list_pending;
        logic owner_change_req;
        logic [1:0] overrun_tally_field;
    } cmd_bits_t;

    typedef struct packed {
        soft_reset_state_t sr_state;
        logic [RESET_CNT_W-1:0] sr_cnt;
        cmd_bits_t cmd;
        logic [EV_WIDTH-1:0] ev_status;
        logic [EV_WIDTH-1:0] ev_mask;
        logic [31:0] rdata;
        logic irq;
        logic owner_flag_set;
        logic oper_reset;
        logic bus_block;
        logic suspend;
        logic bulk_go;
        logic control_go;
    } state_t;

endpackage : cmd_status_pkg
`default_nettype wire

// ### hdl/usb_host_command_status.sv
// Command and status register of the host controller with its list-pending handshake
// ==========================================
`timescale 1ns/1ps
`default_nettype none

module usb_host_command_status (
    input wire logic CLOCK, // System clock, 200 MHz
    input wire logic SYS_RST, // Synchronous reset, active high
    input wire logic [15:0] ADDR, // Register byte address
    input wire logic [31:0] WDATA, // Write data
    input wire logic WR, // Write strobe
    input wire logic RD, // Read strobe
    input wire logic OVERRUN_EVT, // Scheduling overrun pulse from the frame logic
    input wire logic HANDOVER_DONE, // Ownership handover complete pulse
    input wire logic BULK_HEAD, // Engine reached bulk list head, pulse
    input wire logic BULK_TD_FOUND, // Descriptor found while walking bulk list, pulse
    input wire logic CONTROL_HEAD, // Engine reached control list head, pulse
    input wire logic CONTROL_TD_FOUND, // Descriptor found while walking control list, pulse
    output logic [31:0] RDATA, // Read data, valid the cycle after RD
    output logic IRQ, // Level interrupt, unmasked local status set
    output logic OWNER_CHANGE_SET, // Sets ownership-change flag while request stands
    output logic BULK_START, // Start bulk list processing, pulse
    output logic CONTROL_START, // Start control list processing, pulse
    output logic BULK_PENDING, // Current bulk pending bit
    output logic CONTROL_PENDING, // Current control pending bit
    output logic OPER_RESET, // Reset to operational registers, level
    output logic BUS_BLOCK, // Host bus accesses blocked, level
    output logic SUSPEND // Controller held in suspend state
);

    cmd_status_pkg::state_t s_q;
    cmd_status_pkg::state_t s_d;

    function automatic logic hit(input logic [15:0] a, input logic [15:0] off);
        hit = (a == off);
    endfunction : hit

    logic wr_cmd;
    logic rd_cmd;
    logic rd_sts;
    logic rd_msk;
    logic bulk_found;
    logic control_found;
    logic [cmd_status_pkg::EV_WIDTH-1:0] ev_new;

    // ==========================================
    // Next state
    always_comb
    begin
        s_d = s_q;
        wr_cmd = WR && hit(ADDR, cmd_status_pkg::CMD_STATUS_OFFSET);
        rd_cmd = RD && hit(ADDR, cmd_status_pkg::CMD_STATUS_OFFSET);
        rd_sts = RD && hit(ADDR, cmd_status_pkg::IRQ_STATUS_OFFSET);
        rd_msk = RD && hit(ADDR, cmd_status_pkg::IRQ_MASK_OFFSET);
        // Found and head are distinct pulses; head with no found means a quiet list
        bulk_found = BULK_TD_FOUND && s_q.cmd.bulk_list_pending == 1'b0;
        control_found = CONTROL_TD_FOUND && s_q.cmd.control_list_pending == 1'b0;
        ev_new = '0;
        s_d.bulk_go = 1'b0;
        s_d.control_go = 1'b0;

        // Tally runs free and wraps by width
        if (OVERRUN_EVT)
        begin
            s_d.cmd.overrun_tally_field = s_q.cmd.overrun_tally_field + 2'h1;
            ev_new[cmd_status_pkg::EV_OVERRUN_POS] = 1'b1;
        end

        // Engine-side list handshake; software set below wins over engine clear
        if (BULK_HEAD && s_q.cmd.bulk_list_pending)
        begin
            s_d.bulk_go = 1'b1;
            s_d.cmd.bulk_list_pending = 1'b0;
        end
        if (BULK_TD_FOUND)
            s_d.cmd.bulk_list_pending = 1'b1;
        if (CONTROL_HEAD && s_q.cmd.control_list_pending)
        begin
            s_d.control_go = 1'b1;
            s_d.cmd.control_list_pending = 1'b0;
        end
        if (CONTROL_TD_FOUND)
            s_d.cmd.control_list_pending = 1'b1;

        if (HANDOVER_DONE && s_q.cmd.owner_change_req)
        begin
            s_d.cmd.owner_change_req = 1'b0;
            ev_new[cmd_status_pkg::EV_OWNER_POS] = 1'b1;
        end

        // Soft reset sequence: fixed hold, then self-clear
        case (s_q.sr_state)
            cmd_status_pkg::SR_IDLE:
            begin
                if (s_q.cmd.soft_reset_cmd)
                begin
                    s_d.sr_state = cmd_status_pkg::SR_HOLD;
                    s_d.sr_cnt = '0;
                end
            end
            cmd_status_pkg::SR_HOLD:
            begin
                s_d.sr_cnt = s_q.sr_cnt + 12'h001;
                if (s_q.sr_cnt == 12'(cmd_status_pkg::RESET_HOLD_CYCLES - 1))
                    s_d.sr_state = cmd_status_pkg::SR_DONE;
            end
            cmd_status_pkg::SR_DONE:
            begin
                s_d.cmd.soft_reset_cmd = 1'b0;
                ev_new[cmd_status_pkg::EV_RESET_DONE_POS] = 1'b1;
                s_d.sr_state = cmd_status_pkg::SR_IDLE;
            end
            default:
                s_d.sr_state = cmd_status_pkg::SR_IDLE;
        endcase
        // Reset reaches only operational registers; no root hub reset output exists
        s_d.oper_reset = (s_d.sr_state == cmd_status_pkg::SR_HOLD);
        s_d.bus_block = (s_d.sr_state == cmd_status_pkg::SR_HOLD);
        s_d.suspend = (s_d.sr_state == cmd_status_pkg::SR_HOLD);

        // Command writes set only, zeros change nothing; a mask write replaces the whole mask
        if (wr_cmd)
        begin
            if (WDATA[cmd_status_pkg::SOFT_RESET_POS])
                s_d.cmd.soft_reset_cmd = 1'b1;
            if (WDATA[cmd_status_pkg::CONTROL_PENDING_POS])
                s_d.cmd.control_list_pending = 1'b1;
            if (WDATA[cmd_status_pkg::BULK_PENDING_POS])
                s_d.cmd.bulk_list_pending = 1'b1;
            if (WDATA[cmd_status_pkg::OWNER_CHANGE_POS])
                s_d.cmd.owner_change_req = 1'b1;
        end
        if (WR && hit(ADDR, cmd_status_pkg::IRQ_MASK_OFFSET))
            s_d.ev_mask = WDATA[cmd_status_pkg::EV_WIDTH-1:0];

        // Read clears status, a new event in the same cycle stays set
        if (rd_sts)
            s_d.ev_status = ev_new;
        else
            s_d.ev_status = s_q.ev_status | ev_new;
        s_d.irq = |(s_d.ev_status & s_d.ev_mask);

        s_d.owner_flag_set = s_d.cmd.owner_change_req;

        s_d.rdata = '0;
        if (rd_cmd)
        begin
            s_d.rdata[cmd_status_pkg::SOFT_RESET_POS] = s_q.cmd.soft_reset_cmd;
            s_d.rdata[cmd_status_pkg::CONTROL_PENDING_POS] = s_q.cmd.control_list_pending;
            s_d.rdata[cmd_status_pkg::BULK_PENDING_POS] = s_q.cmd.bulk_list_pending;
            s_d.rdata[cmd_status_pkg::OWNER_CHANGE_POS] = s_q.cmd.owner_change_req;
            s_d.rdata[cmd_status_pkg::TALLY_MSB:cmd_status_pkg::TALLY_LSB] =
                s_q.cmd.overrun_tally_field;
        end
        else if (rd_sts)
            s_d.rdata[cmd_status_pkg::EV_WIDTH-1:0] = s_q.ev_status;
        else if (rd_msk)
            s_d.rdata[cmd_status_pkg::EV_WIDTH-1:0] = s_q.ev_mask;
    end

    // ==========================================
    // State register
    always_ff @(posedge CLOCK)
    begin
        if (SYS_RST)
        begin
            s_q <= '0;
            s_q.sr_state <= cmd_status_pkg::SR_IDLE;
            s_q.cmd.overrun_tally_field <= cmd_status_pkg::TALLY_RESET;
            s_q.ev_status <= cmd_status_pkg::EV_RESET;
            s_q.ev_mask <= cmd_status_pkg::EV_RESET;
            s_q.rdata <= cmd_status_pkg::RDATA_RESET;
        end
        else
            s_q <= s_d;
    end

    assign RDATA = s_q.rdata;
    assign IRQ = s_q.irq;
    assign OWNER_CHANGE_SET = s_q.owner_flag_set;
    assign BULK_START = s_q.bulk_go;
    assign CONTROL_START = s_q.control_go;
    assign BULK_PENDING = s_q.cmd.bulk_list_pending;
    assign CONTROL_PENDING = s_q.cmd.control_list_pending;
    assign OPER_RESET = s_q.oper_reset;
    assign BUS_BLOCK = s_q.bus_block;
    assign SUSPEND = s_q.suspend;

    // ==========================================
    // Checks

    logic [12:0] sr_age_q;
    always_ff @(posedge CLOCK)
    begin
        if (SYS_RST || !s_q.cmd.soft_reset_cmd)
            sr_age_q <= '0;
        else if (sr_age_q != 13'h1fff)
            sr_age_q <= sr_age_q + 13'h0001;
    end

    a_tally_wraps: assert property (@(posedge CLOCK) disable iff (SYS_RST)
        OVERRUN_EVT |=> s_q.cmd.overrun_tally_field == $past(s_q.cmd.overrun_tally_field) + 2'h1)
        else $error("overrun tally did not advance");
    a_tally_with_flag: assert property (@(posedge CLOCK) disable iff (SYS_RST)
        OVERRUN_EVT && s_q.ev_status[cmd_status_pkg::EV_OVERRUN_POS]
        |=> s_q.cmd.overrun_tally_field != $past(s_q.cmd.overrun_tally_field))
        else $error("tally held while overrun flag set");
    a_owner_flag: assert property (@(posedge CLOCK) disable iff (SYS_RST)
        s_q.cmd.owner_change_req |-> OWNER_CHANGE_SET)
        else $error("ownership flag not raised during request");
    a_owner_clear: assert property (@(posedge CLOCK) disable iff (SYS_RST)
        HANDOVER_DONE && !(wr_cmd && WDATA[3]) |=> !s_q.cmd.owner_change_req)
        else $error("request not cleared after handover");
    a_bulk_no_start: assert property (@(posedge CLOCK) disable iff (SYS_RST)
        BULK_HEAD && !s_q.cmd.bulk_list_pending |=> !BULK_START)
        else $error("bulk started with pending clear");
    a_bulk_start_clear: assert property (@(posedge CLOCK) disable iff (SYS_RST)
        BULK_HEAD && s_q.cmd.bulk_list_pending && !BULK_TD_FOUND && !wr_cmd
        |=> BULK_START && !BULK_PENDING)
        else $error("bulk start or clear missing");
    a_bulk_refill: assert property (@(posedge CLOCK) disable iff (SYS_RST)
        BULK_TD_FOUND |=> BULK_PENDING)
        else $error("bulk pending not refilled");
    a_ctrl_no_start: assert property (@(posedge CLOCK) disable iff (SYS_RST)
        CONTROL_HEAD && !s_q.cmd.control_list_pending |=> !CONTROL_START)
        else $error("control started with pending clear");
    a_ctrl_start_clear: assert property (@(posedge CLOCK) disable iff (SYS_RST)
        CONTROL_HEAD && s_q.cmd.control_list_pending && !CONTROL_TD_FOUND && !wr_cmd
        |=> CONTROL_START && !CONTROL_PENDING)
        else $error("control start or clear missing");
    a_ctrl_refill: assert property (@(posedge CLOCK) disable iff (SYS_RST)
        CONTROL_TD_FOUND |=> CONTROL_PENDING)
        else $error("control pending not refilled");
    a_reset_blocks: assert property (@(posedge CLOCK) disable iff (SYS_RST)
        s_q.sr_state == cmd_status_pkg::SR_HOLD |-> BUS_BLOCK && SUSPEND && OPER_RESET)
        else $error("soft reset not blocking bus");
    a_reset_time: assert property (@(posedge CLOCK) disable iff (SYS_RST)
        sr_age_q <= 13'(cmd_status_pkg::RESET_LIMIT_CYCLES))
        else $error("soft reset exceeded limit");
    a_zero_write: assert property (@(posedge CLOCK) disable iff (SYS_RST)
        wr_cmd && WDATA[3:0] == 4'h0 && !HANDOVER_DONE && s_q.cmd.owner_change_req
        |=> s_q.cmd.owner_change_req)
        else $error("zero write cleared request");

    // ==========================================
    // Checks on tally and ownership
    a_tally_hold: assert property (@(posedge CLOCK) disable iff (SYS_RST)
        !OVERRUN_EVT |=> s_q.cmd.overrun_tally_field == $past(s_q.cmd.overrun_tally_field))
        else $error("overrun tally moved without an overrun");

    // Read data carry the tally as it stood at the read strobe
    a_tally_read: assert property (@(posedge CLOCK) disable iff (SYS_RST)
        rd_cmd |=> RDATA[cmd_status_pkg::TALLY_MSB:cmd_status_pkg::TALLY_LSB] ==
            $past(s_q.cmd.overrun_tally_field))
        else $error("tally read back wrong");

    a_owner_set: assert property (@(posedge CLOCK) disable iff (SYS_RST)
        wr_cmd && WDATA[cmd_status_pkg::OWNER_CHANGE_POS] |=> OWNER_CHANGE_SET)
        else $error("ownership flag missing after request write");

    // A request stays down until software writes a one again
    a_owner_hold: assert property (@(posedge CLOCK) disable iff (SYS_RST)
        !s_q.cmd.owner_change_req && !(wr_cmd && WDATA[cmd_status_pkg::OWNER_CHANGE_POS])
        |=> !OWNER_CHANGE_SET)
        else $error("ownership request rose on its own");

    a_owner_status: assert property (@(posedge CLOCK) disable iff (SYS_RST)
        HANDOVER_DONE && s_q.cmd.owner_change_req
        |=> s_q.ev_status[cmd_status_pkg::EV_OWNER_POS])
        else $error("handover not recorded in status");

    // ==========================================
    // Checks on the list handshake
    a_bulk_sw_set: assert property (@(posedge CLOCK) disable iff (SYS_RST)
        wr_cmd && WDATA[cmd_status_pkg::BULK_PENDING_POS] |=> BULK_PENDING)
        else $error("bulk pending write lost");

    // Only a descriptor or a software write may raise an empty list
    a_bulk_stop: assert property (@(posedge CLOCK) disable iff (SYS_RST)
        !BULK_PENDING && !BULK_TD_FOUND && !(wr_cmd && WDATA[cmd_status_pkg::BULK_PENDING_POS])
        |=> !BULK_PENDING)
        else $error("bulk pending rose with no cause");

    a_bulk_start_cause: assert property (@(posedge CLOCK) disable iff (SYS_RST)
        BULK_START |-> $past(BULK_HEAD) && $past(s_q.cmd.bulk_list_pending))
        else $error("bulk started without head and pending");

    a_bulk_zero_keep: assert property (@(posedge CLOCK) disable iff (SYS_RST)
        wr_cmd && !WDATA[cmd_status_pkg::BULK_PENDING_POS] && !BULK_HEAD && BULK_PENDING
        |=> BULK_PENDING)
        else $error("zero write dropped bulk pending");

    a_ctrl_sw_set: assert property (@(posedge CLOCK) disable iff (SYS_RST)
        wr_cmd && WDATA[cmd_status_pkg::CONTROL_PENDING_POS] |=> CONTROL_PENDING)
        else $error("control pending write lost");

    a_ctrl_stop: assert property (@(posedge CLOCK) disable iff (SYS_RST)
        !CONTROL_PENDING && !CONTROL_TD_FOUND
        && !(wr_cmd && WDATA[cmd_status_pkg::CONTROL_PENDING_POS])
        |=> !CONTROL_PENDING)
        else $error("control pending rose with no cause");

    a_ctrl_start_cause: assert property (@(posedge CLOCK) disable iff (SYS_RST)
        CONTROL_START |-> $past(CONTROL_HEAD) && $past(s_q.cmd.control_list_pending))
        else $error("control started without head and pending");

    a_ctrl_zero_keep: assert property (@(posedge CLOCK) disable iff (SYS_RST)
        wr_cmd && !WDATA[cmd_status_pkg::CONTROL_PENDING_POS]
        && !CONTROL_HEAD && CONTROL_PENDING
        |=> CONTROL_PENDING)
        else $error("zero write dropped control pending");

    // ==========================================
    // Checks on the soft reset sequence
    a_reset_entry: assert property (@(posedge CLOCK) disable iff (SYS_RST)
        s_q.sr_state == cmd_status_pkg::SR_IDLE && s_q.cmd.soft_reset_cmd
        |=> SUSPEND && BUS_BLOCK && OPER_RESET)
        else $error("soft reset did not enter suspend");

    a_soft_set: assert property (@(posedge CLOCK) disable iff (SYS_RST)
        wr_cmd && WDATA[cmd_status_pkg::SOFT_RESET_POS] |=> s_q.cmd.soft_reset_cmd)
        else $error("soft reset write lost");

    // The hold count must never run past its end, or the limit is at risk
    a_reset_hold_len: assert property (@(posedge CLOCK) disable iff (SYS_RST)
        s_q.sr_state == cmd_status_pkg::SR_HOLD |->
            s_q.sr_cnt < 12'(cmd_status_pkg::RESET_HOLD_CYCLES))
        else $error("soft reset hold overran its count");

    a_reset_self_clear: assert property (@(posedge CLOCK) disable iff (SYS_RST)
        s_q.sr_state == cmd_status_pkg::SR_DONE
        && !(wr_cmd && WDATA[cmd_status_pkg::SOFT_RESET_POS]) |=> !s_q.cmd.soft_reset_cmd)
        else $error("soft reset bit not cleared at the end");

    a_reset_done_flag: assert property (@(posedge CLOCK) disable iff (SYS_RST)
        s_q.sr_state == cmd_status_pkg::SR_DONE
        |=> s_q.ev_status[cmd_status_pkg::EV_RESET_DONE_POS])
        else $error("reset done not recorded in status");

    // Outside the hold the rest of the controller must see the bus open again
    a_reset_release: assert property (@(posedge CLOCK) disable iff (SYS_RST)
        s_q.sr_state != cmd_status_pkg::SR_HOLD |-> !SUSPEND && !BUS_BLOCK && !OPER_RESET)
        else $error("soft reset outputs stuck");

    // ==========================================
    // Coverage of the main scenarios
    c_overrun_wrap: cover property (@(posedge CLOCK)
        OVERRUN_EVT && s_q.cmd.overrun_tally_field == 2'h3);
    c_bulk_start: cover property (@(posedge CLOCK) BULK_START);
    c_ctrl_start: cover property (@(posedge CLOCK) CONTROL_START);
    c_soft_reset: cover property (@(posedge CLOCK) s_q.sr_state == cmd_status_pkg::SR_DONE);
    c_list_rearm: cover property (@(posedge CLOCK) bulk_found || control_found);

endmodule : usb_host_command_status
`default_nettype wire

// ### sim/tb_usb_host_command_status.sv
// Self-checking testbench for the command and status register block
`timescale 1ns/1ps
`default_nettype none

module tb_usb_host_command_status;
    logic CLOCK = 1'b0;
    logic SYS_RST = 1'b1;
    logic [15:0] ADDR = 16'h0;
    logic [31:0] WDATA = 32'h0;
    logic WR = 1'b0;
    logic RD = 1'b0;
    logic [5:0] ev = 6'h0;
    logic [31:0] RDATA;
    logic IRQ, OWNER_CHANGE_SET, BULK_START, CONTROL_START, BULK_PENDING, CONTROL_PENDING;
    logic OPER_RESET, BUS_BLOCK, SUSPEND;
    int mismatches = 0;
    int checks_done = 0;
    logic [31:0] rd_val;

    always #2.5 CLOCK = ~CLOCK;

    usb_host_command_status dut (
        .CLOCK(CLOCK), .SYS_RST(SYS_RST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
        .OVERRUN_EVT(ev[0]), .HANDOVER_DONE(ev[1]), .BULK_HEAD(ev[2]),
        .BULK_TD_FOUND(ev[3]), .CONTROL_HEAD(ev[4]), .CONTROL_TD_FOUND(ev[5]),
        .RDATA(RDATA), .IRQ(IRQ), .OWNER_CHANGE_SET(OWNER_CHANGE_SET),
        .BULK_START(BULK_START), .CONTROL_START(CONTROL_START),
        .BULK_PENDING(BULK_PENDING), .CONTROL_PENDING(CONTROL_PENDING),
        .OPER_RESET(OPER_RESET), .BUS_BLOCK(BUS_BLOCK), .SUSPEND(SUSPEND)
    );

    // ==========================================
    // Shared helpers
    task automatic complete_run;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : complete_run

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp)
        begin
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
            mismatches++;
        end
    endtask : check

    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        @(posedge CLOCK);
        ADDR <= a;
        WDATA <= d;
        WR <= 1'b1;
        @(posedge CLOCK);
        WR <= 1'b0;
    endtask : wr

    // Read data stand only in the cycle after the strobe edge
    task automatic rd(input logic [15:0] a);
        @(posedge CLOCK);
        ADDR <= a;
        RD <= 1'b1;
        @(posedge CLOCK);
        RD <= 1'b0;
        #1;
        rd_val = RDATA;
    endtask : rd

    task automatic pulse(input int idx);
        @(posedge CLOCK);
        ev[idx] <= 1'b1;
        @(posedge CLOCK);
        ev[idx] <= 1'b0;
        #1;
    endtask : pulse

    // ==========================================
    // Scenarios
    task automatic reset_values;
        check("outputs after reset", 32'h0, {23'h0, IRQ, OWNER_CHANGE_SET, BULK_START,
            CONTROL_START, BULK_PENDING, CONTROL_PENDING, OPER_RESET, BUS_BLOCK, SUSPEND});
        rd(16'hd008);
        check("command_status reset", 32'h0, rd_val);
        rd(16'hd0f0);
        check("unmapped read", 32'h0, rd_val);
        wr(16'hd104, 32'h7);
        rd(16'hd104);
        check("mask readback", 32'h7, rd_val);
    endtask : reset_values

    // Bulk list when is_bulk is set, control list otherwise
    task automatic list_flow(input bit is_bulk);
        int h;
        h = is_bulk ? 2 : 4;
        pulse(h);
        check("start on empty", 32'h0, is_bulk ? BULK_START : CONTROL_START);
        wr(16'hd008, is_bulk ? 32'h4 : 32'h2);
        #1;
        check("pending set", 32'h1, is_bulk ? BULK_PENDING : CONTROL_PENDING);
        wr(16'hd008, 32'h0);
        #1;
        check("pending after zero", 32'h1, is_bulk ? BULK_PENDING : CONTROL_PENDING);
        pulse(h);
        check("start", 32'h1, is_bulk ? BULK_START : CONTROL_START);
        check("pending cleared", 32'h0, is_bulk ? BULK_PENDING : CONTROL_PENDING);
        pulse(h + 1);
        check("pending on td", 32'h1, is_bulk ? BULK_PENDING : CONTROL_PENDING);
        pulse(h);
        check("start again", 32'h1, is_bulk ? BULK_START : CONTROL_START);
        pulse(h);
        check("stop", 32'h0, is_bulk ? BULK_START : CONTROL_START);
        check("pending stays zero", 32'h0, is_bulk ? BULK_PENDING : CONTROL_PENDING);
    endtask : list_flow

    task automatic overrun_tally;
        wr(16'hd104, 32'h1);
        for (int i = 1; i <= 5; i++)
        begin
            pulse(0);
            rd(16'hd008);
            check("tally", 32'(i % 4) << 16, rd_val);
            wr(16'hd008, 32'h0003_0000);
            rd(16'hd008);
            check("tally after write", 32'(i % 4) << 16, rd_val);
        end
        check("irq raised", 32'h1, IRQ);
        wr(16'hd104, 32'h0);
        #1;
        repeat (2) @(posedge CLOCK);
        #1;
        check("irq masked", 32'h0, IRQ);
        rd(16'hd100);
        check("overrun status", 32'h1, rd_val);
        wr(16'hd104, 32'h7);
        repeat (2) @(posedge CLOCK);
        #1;
        check("irq after clear", 32'h0, IRQ);
    endtask : overrun_tally

    task automatic owner_change;
        wr(16'hd008, 32'h8);
        repeat (2) @(posedge CLOCK);
        #1;
        check("owner flag set", 32'h1, OWNER_CHANGE_SET);
        rd(16'hd008);
        check("owner request bit", 32'h8, rd_val & 32'hf);
        pulse(1);
        repeat (3) @(posedge CLOCK);
        #1;
        check("owner flag gone", 32'h0, OWNER_CHANGE_SET);
        rd(16'hd008);
        check("owner request cleared", 32'h0, rd_val & 32'hf);
        check("irq on handover", 32'h1, IRQ);
        rd(16'hd100);
        check("handover status", 32'h2, rd_val);
    endtask : owner_change

    task automatic soft_reset;
        int busy;
        busy = 0;
        wr(16'hd008, 32'h1);
        rd(16'hd008);
        check("reset bit set", 32'h1, rd_val & 32'hf);
        check("suspend entered", 32'h7, {29'h0, SUSPEND, OPER_RESET, BUS_BLOCK});
        for (int i = 0; i < 3000 && SUSPEND === 1'b1; i++)
        begin
            busy++;
            if ({OPER_RESET, BUS_BLOCK} !== 2'b11)
                check("reset outputs held", 32'h3, {30'h0, OPER_RESET, BUS_BLOCK});
            @(posedge CLOCK);
            #1;
        end
        check("reset within limit", 32'h1,
            32'(busy < cmd_status_pkg::RESET_LIMIT_CYCLES));
        repeat (2) @(posedge CLOCK);
        rd(16'hd008);
        check("reset bit cleared", 32'h0, rd_val & 32'hf);
        rd(16'hd100);
        check("reset done status", 32'h4, rd_val);
    endtask : soft_reset

    // ==========================================
    // Main sequence and watchdog
    initial
    begin
        repeat (10) @(posedge CLOCK);
        SYS_RST <= 1'b0;
        @(posedge CLOCK);
        #1;
        reset_values();
        list_flow(1'b1);
        list_flow(1'b0);
        overrun_tally();
        owner_change();
        soft_reset();
        complete_run();
    end

    initial
    begin
        repeat (20000) @(posedge CLOCK);
        mismatches++;
        complete_run();
    end
endmodule : tb_usb_host_command_status

`default_nettype wire
